/* File: src/msido_pkg.sv */
/*
  shared constants, register map and carrier types of the status input and
  discrete output block.
  assumes a single 20 MHz system clock and an apb register bus with 32-bit data.
*/
package msido_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned MS_NS           = 1_000_000;
  localparam int unsigned TICK_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned ENERGY_PULSE_MS = 20;
  localparam int unsigned MS_PER_S        = 1000;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int unsigned DB_W  = 14;
  localparam int unsigned TMR_W = 24;
  localparam int unsigned ADR_W = 12;
  localparam int unsigned IRQ_W = 3;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_IN_MODE   = 12'h000;
  localparam logic [11:0] OFS_DEBOUNCE0 = 12'h004;
  localparam logic [11:0] OFS_DEBOUNCE1 = 12'h008;
  localparam logic [11:0] OFS_OUT_CFG0  = 12'h00C;
  localparam logic [11:0] OFS_OUT_CFG1  = 12'h010;
  localparam logic [11:0] OFS_ON_TIME0  = 12'h014;
  localparam logic [11:0] OFS_ON_TIME1  = 12'h018;
  localparam logic [11:0] OFS_COUNT0    = 12'h01C;
  localparam logic [11:0] OFS_COUNT1    = 12'h020;
  localparam logic [11:0] OFS_STATE     = 12'h024;
  localparam logic [11:0] OFS_DEM_SEL   = 12'h028;
  localparam logic [11:0] OFS_DEM_LIMIT = 12'h02C;
  localparam logic [11:0] OFS_DEM_DROP  = 12'h030;
  localparam logic [11:0] OFS_IRQ_STAT  = 12'h034;
  localparam logic [11:0] OFS_IRQ_CLR   = 12'h038;
  localparam logic [11:0] OFS_IRQ_EN    = 12'h03C;

  // ----------------------------------------------------------------------
  // interrupt bits and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned IRQ_IN0   = 0;
  localparam int unsigned IRQ_IN1   = 1;
  localparam int unsigned IRQ_ALARM = 2;
  localparam logic [4:0]  OUT_CFG_RST = 5'h10;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {CTL_EXTERNAL, CTL_ALARM, CTL_ENERGY} msido_ctl_t;
  typedef enum logic [1:0] {DEM_PRESENT, DEM_LAST, DEM_PREDICT} msido_dem_t;

  // bit 4 polarity, bit 3 timed, bit 2 command, bits 1:0 control mode
  typedef struct packed {
    logic       polarity;
    logic       timed;
    logic       cmd;
    logic [1:0] mode;
  } msido_out_cfg_t;

  typedef struct packed {
    logic [ADR_W-1:0] paddr;
    logic             psel;
    logic             penable;
    logic             pwrite;
    logic [31:0]      pwdata;
  } msido_apb_req_t;

endpackage

/* File: src/msido_input.sv */
/*
  one status input: two-flop synchroniser, millisecond debounce, edge pulse.
  assumes ms_tick is a one-cycle pulse every millisecond from the parent.
*/
`timescale 1ns/1ps
`default_nettype none

module msido_input (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  // timing and setup
  input  wire logic                     ms_tick,
  input  wire logic [msido_pkg::DB_W-1:0] debounce,
  // pin and result
  input  wire logic                     pin,
  output var  logic                     level,
  output var  logic                     rise
);

  logic                     sync_meta;
  logic                     sync_level;
  logic [msido_pkg::DB_W-1:0] cnt;
  logic                     accept;

  // ----------------------------------------------------------------------
  // synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sync_meta  <= 1'b0;
      sync_level <= 1'b0;
    end else begin
      sync_meta  <= pin;
      sync_level <= sync_meta;
    end
  end

  // ----------------------------------------------------------------------
  // debounce
  // ----------------------------------------------------------------------
  // counter restarts whenever the sampled level returns, so a bounce resets the wait
  assign accept = (sync_level != level) && (cnt >= debounce);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt   <= '0;
      level <= 1'b0;
      rise  <= 1'b0;
    end else begin
      rise <= accept && sync_level;
      if (accept) begin
        level <= sync_level;
        cnt   <= '0;
      end else if (sync_level == level) begin
        cnt <= '0;
      end else if (ms_tick) begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  chk_debounce_wait: assert property (@(posedge clock) disable iff (sys_rst)
    $changed(level) |-> $past(sync_level != level) && $past(cnt) >= $past(debounce))
    else $error("status input level changed before debounce time");

  chk_rise_edge: assert property (@(posedge clock) disable iff (sys_rst)
    rise |-> level && !$past(level))
    else $error("pulse reported without rising accepted level");

endmodule

`default_nettype wire

/* File: src/msido_top.sv */
/*
  status inputs with pulse counting or demand resync, two discrete outputs
  driven by command, demand alarm or energy pulses, apb registers, interrupt.
  assumes apb master on clock, asynchronous pins, demand values from meter core.
*/
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module msido_top #(
  parameter int unsigned TICK_CYCLES = msido_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        sys_rst,
  // apb slave
  input  wire logic [msido_pkg::ADR_W-1:0] paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  output var  logic [31:0]                 prdata,
  output var  logic                        pready,
  output var  logic                        pslverr,
  // status input pins
  input  wire logic                        status_input_one,
  input  wire logic                        status_input_two,
  // meter core
  input  wire logic [31:0]                 demand_present,
  input  wire logic [31:0]                 demand_last,
  input  wire logic [31:0]                 demand_predict,
  input  wire logic [1:0]                  energy_pulse,
  output var  logic                        demand_restart,
  // discrete output pins, high closes the switch
  output var  logic                        discrete_output_one,
  output var  logic                        discrete_output_two,
  // interrupt
  output var  logic                        irq
);

  msido_pkg::msido_apb_req_t  req;
  msido_pkg::msido_out_cfg_t  out_cfg [2];
  logic [msido_pkg::DB_W-1:0] debounce [2];
  logic [msido_pkg::DB_W-1:0] on_time [2];
  logic [31:0]                count [2];
  logic [1:0]                 in_sync_mode;
  logic [1:0]                 in_level;
  logic [1:0]                 in_rise;
  logic [1:0]                 dem_sel;
  logic [31:0]                dem_limit;
  logic [31:0]                dem_drop;
  logic [31:0]                dem_value;
  logic                       alarm_on;
  logic                       alarm_prev;
  logic [msido_pkg::IRQ_W-1:0] irq_stat;
  logic [msido_pkg::IRQ_W-1:0] irq_en;
  logic [msido_pkg::IRQ_W-1:0] irq_event;
  logic [31:0]                tick_cnt;
  logic                       ms_tick;
  logic [msido_pkg::TMR_W-1:0] timer [2];
  logic [31:0]                sub [2];
  logic [1:0]                 src_prev;
  logic [1:0]                 act;
  logic [1:0]                 next_act;
  logic [1:0]                 src;
  logic                       wr;
  logic                       rd;
  logic                       hit;
  logic [31:0]                next_rdata;

  assign req = '{paddr: paddr, psel: psel, penable: penable, pwrite: pwrite, pwdata: pwdata};

  // ----------------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt <= '0;
      ms_tick  <= 1'b0;
    end else begin
      ms_tick <= (tick_cnt == TICK_CYCLES - 1);
      if (tick_cnt == TICK_CYCLES - 1) begin
        tick_cnt <= '0;
      end else begin
        tick_cnt <= tick_cnt + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // status inputs
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_in
    msido_input u_in (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .ms_tick  (ms_tick),
      .debounce (debounce[i]),
      .pin      (i == 0 ? status_input_one : status_input_two),
      .level    (in_level[i]),
      .rise     (in_rise[i])
    );
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count[0]       <= '0;
      count[1]       <= '0;
      demand_restart <= 1'b0;
    end else begin
      // a sync-mode input feeds the demand period and its interrupt bit, never the counter
      demand_restart <= |(in_rise & in_sync_mode);
      for (int i = 0; i < 2; i++) begin
        if (in_rise[i] && !in_sync_mode[i]) begin
          count[i] <= count[i] + 32'h0000_0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // demand alarm
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (msido_pkg::msido_dem_t'(dem_sel))
      msido_pkg::DEM_PRESENT: dem_value = demand_present;
      msido_pkg::DEM_LAST:    dem_value = demand_last;
      msido_pkg::DEM_PREDICT: dem_value = demand_predict;
      default:                dem_value = demand_present;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      alarm_on <= 1'b0;
    end else if (dem_value > dem_limit) begin
      alarm_on <= 1'b1;
    end else if (dem_value < dem_drop) begin
      alarm_on <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // discrete outputs
  // ----------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      src[i] = (out_cfg[i].mode == msido_pkg::CTL_ALARM) ? alarm_on : out_cfg[i].cmd;
      if (out_cfg[i].mode == msido_pkg::CTL_ENERGY || out_cfg[i].timed) begin
        next_act[i] = (timer[i] != '0);
      end else begin
        next_act[i] = src[i];
      end
    end
  end

  // timer holds remaining milliseconds, sub counts cycles inside one, so width is exact
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 2; i++) begin
        timer[i] <= '0;
        sub[i]   <= '0;
      end
      src_prev <= '0;
    end else begin
      src_prev <= src;
      for (int i = 0; i < 2; i++) begin
        if (out_cfg[i].mode == msido_pkg::CTL_ENERGY && energy_pulse[i]) begin
          timer[i] <= msido_pkg::TMR_W'(msido_pkg::ENERGY_PULSE_MS);
          sub[i]   <= '0;
        end else if (out_cfg[i].mode != msido_pkg::CTL_ENERGY && out_cfg[i].timed
                     && src[i] && !src_prev[i]) begin
          timer[i] <= msido_pkg::TMR_W'(on_time[i] * msido_pkg::MS_PER_S);
          sub[i]   <= '0;
        end else if (timer[i] != '0) begin
          if (sub[i] == TICK_CYCLES - 1) begin
            sub[i]   <= '0;
            timer[i] <= timer[i] - 1'b1;
          end else begin
            sub[i] <= sub[i] + 32'h0000_0001;
          end
        end
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      act                 <= '0;
      discrete_output_one <= 1'b0;
      discrete_output_two <= 1'b0;
    end else begin
      act                 <= next_act;
      // low polarity: active closes; high polarity: active opens
      discrete_output_one <= next_act[0] ^ out_cfg[0].polarity;
      discrete_output_two <= next_act[1] ^ out_cfg[1].polarity;
    end
  end

  // ----------------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------------
  // alarm event is the rising edge of alarm_on, seen against its registered copy
  assign irq_event = {alarm_on && !alarm_prev, in_rise};

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat   <= '0;
      irq        <= 1'b0;
      alarm_prev <= 1'b0;
    end else begin
      alarm_prev <= alarm_on;
      // set wins over a clear in the same cycle
      if (wr && req.paddr == msido_pkg::OFS_IRQ_CLR) begin
        irq_stat <= (irq_stat & ~req.pwdata[msido_pkg::IRQ_W-1:0]) | irq_event;
      end else begin
        irq_stat <= irq_stat | irq_event;
      end
      irq <= |(irq_stat & irq_en);
    end
  end

  // ----------------------------------------------------------------------
  // apb slave: one wait state, pready registered
  // ----------------------------------------------------------------------
  assign wr = req.psel && req.penable && pready && req.pwrite;
  assign rd = req.psel && req.penable && !pready && !req.pwrite;

  always_comb begin
    hit        = 1'b1;
    next_rdata = '0;
    unique case (req.paddr)
      msido_pkg::OFS_IN_MODE:   next_rdata = {30'h0000_0000, in_sync_mode};
      msido_pkg::OFS_DEBOUNCE0: next_rdata = {18'h0_0000, debounce[0]};
      msido_pkg::OFS_DEBOUNCE1: next_rdata = {18'h0_0000, debounce[1]};
      msido_pkg::OFS_OUT_CFG0:  next_rdata = {27'h000_0000, out_cfg[0]};
      msido_pkg::OFS_OUT_CFG1:  next_rdata = {27'h000_0000, out_cfg[1]};
      msido_pkg::OFS_ON_TIME0:  next_rdata = {18'h0_0000, on_time[0]};
      msido_pkg::OFS_ON_TIME1:  next_rdata = {18'h0_0000, on_time[1]};
      msido_pkg::OFS_COUNT0:    next_rdata = count[0];
      msido_pkg::OFS_COUNT1:    next_rdata = count[1];
      msido_pkg::OFS_STATE:     next_rdata = {27'h000_0000, alarm_on, act, in_level};
      msido_pkg::OFS_DEM_SEL:   next_rdata = {30'h0000_0000, dem_sel};
      msido_pkg::OFS_DEM_LIMIT: next_rdata = dem_limit;
      msido_pkg::OFS_DEM_DROP:  next_rdata = dem_drop;
      msido_pkg::OFS_IRQ_STAT:  next_rdata = {29'h0000_0000, irq_stat};
      msido_pkg::OFS_IRQ_CLR:   next_rdata = '0;
      msido_pkg::OFS_IRQ_EN:    next_rdata = {29'h0000_0000, irq_en};
      default:                  hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= req.psel && req.penable && !pready;
      pslverr <= req.psel && req.penable && !pready && !hit;
      if (rd) begin
        prdata <= hit ? next_rdata : '0;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      in_sync_mode <= '0;
      debounce[0]  <= '0;
      debounce[1]  <= '0;
      on_time[0]   <= '0;
      on_time[1]   <= '0;
      out_cfg[0]   <= msido_pkg::OUT_CFG_RST;
      out_cfg[1]   <= msido_pkg::OUT_CFG_RST;
      dem_sel      <= '0;
      dem_limit    <= 32'hFFFF_FFFF;
      dem_drop     <= '0;
      irq_en       <= '0;
    end else if (wr) begin
      unique case (req.paddr)
        msido_pkg::OFS_IN_MODE:   in_sync_mode <= req.pwdata[1:0];
        msido_pkg::OFS_DEBOUNCE0: debounce[0]  <= req.pwdata[msido_pkg::DB_W-1:0];
        msido_pkg::OFS_DEBOUNCE1: debounce[1]  <= req.pwdata[msido_pkg::DB_W-1:0];
        msido_pkg::OFS_OUT_CFG0:  out_cfg[0]   <= req.pwdata[4:0];
        msido_pkg::OFS_OUT_CFG1:  out_cfg[1]   <= req.pwdata[4:0];
        msido_pkg::OFS_ON_TIME0:  on_time[0]   <= req.pwdata[msido_pkg::DB_W-1:0];
        msido_pkg::OFS_ON_TIME1:  on_time[1]   <= req.pwdata[msido_pkg::DB_W-1:0];
        msido_pkg::OFS_DEM_SEL:   dem_sel      <= req.pwdata[1:0];
        msido_pkg::OFS_DEM_LIMIT: dem_limit    <= req.pwdata;
        msido_pkg::OFS_DEM_DROP:  dem_drop     <= req.pwdata;
        msido_pkg::OFS_IRQ_EN:    irq_en       <= req.pwdata[msido_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic [31:0] act_len [2];
  logic [1:0]  act_pure;

  // a pulse is clean only if energy mode held from its start with no retrigger
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      act_len[0] <= '0;
      act_len[1] <= '0;
      act_pure   <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        act_len[i] <= act[i] ? act_len[i] + 32'h0000_0001 : '0;
        act_pure[i] <= act[i] ? act_pure[i] && out_cfg[i].mode == msido_pkg::CTL_ENERGY && !energy_pulse[i]
                              : out_cfg[i].mode == msido_pkg::CTL_ENERGY;
      end
    end
  end

  chk_count_step: assert property (@(posedge clock) disable iff (sys_rst)
    in_rise[0] && !in_sync_mode[0] |=> count[0] == $past(count[0]) + 32'h0000_0001)
    else $error("input pulse not counted");

  chk_sync_restart: assert property (@(posedge clock) disable iff (sys_rst)
    in_rise[1] && in_sync_mode[1] |=> demand_restart ##1 !demand_restart || (in_rise != 2'b00))
    else $error("demand restart missing after sync pulse");

  chk_polarity_reset: assert property (@(posedge clock)
    sys_rst |=> out_cfg[0].polarity && out_cfg[1].polarity)
    else $error("polarity not high after reset");

  chk_pin_map: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(sys_rst) |-> discrete_output_one == (act[0] ^ $past(out_cfg[0].polarity)))
    else $error("output pin does not follow active state and polarity");

  chk_alarm_raise: assert property (@(posedge clock) disable iff (sys_rst)
    dem_value > dem_limit |=> alarm_on)
    else $error("alarm not raised above upper limit");

  chk_alarm_hold: assert property (@(posedge clock) disable iff (sys_rst)
    alarm_on && dem_value >= dem_drop |=> alarm_on)
    else $error("alarm dropped before drop-out point");

  chk_ext_follow: assert property (@(posedge clock) disable iff (sys_rst)
    out_cfg[0].mode == msido_pkg::CTL_EXTERNAL && !out_cfg[0].timed |=> act[0] == $past(out_cfg[0].cmd))
    else $error("external output does not follow command");

  chk_energy_width: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(act[0]) && act_pure[0]
    |-> act_len[0] == msido_pkg::ENERGY_PULSE_MS * TICK_CYCLES)
    else $error("energy pulse width wrong");

endmodule

`default_nettype wire

/* File: dv/msido_field.sv */
/*
  far-side model: two bouncing contacts and two pulse receivers.
  assumes the bench tells it the idle level of each output pin.
*/
`timescale 1ns/1ps
`default_nettype none

module msido_field (
  // clock
  input  wire logic       clock,
  // discrete outputs and their idle levels
  input  wire logic [1:0] dout,
  input  wire logic [1:0] idle,
  // contacts, open when released
  output var  logic [1:0] contact
);
  int unsigned pulses [2];
  logic [1:0]  dout_q = 2'b00;

  initial contact = 2'b00;

  // a pulse is a move away from idle; a polarity change may count once
  always @(posedge clock) begin
    dout_q <= dout;
    for (int i = 0; i < 2; i++) begin
      if (dout[i] != idle[i] && dout_q[i] == idle[i]) begin
        pulses[i]++;
      end
    end
  end

  // one-cycle bounces, then a settled closure of hi cycles and an open gap
  task automatic press(input int ch, input int bounces, input int hi, input int lo);
    repeat (bounces) begin
      @(posedge clock) contact[ch] <= 1'b1;
      @(posedge clock) contact[ch] <= 1'b0;
    end
    @(posedge clock) contact[ch] <= 1'b1;
    repeat (hi) @(posedge clock);
    contact[ch] <= 1'b0;
    repeat (lo) @(posedge clock);
  endtask
endmodule

`default_nettype wire

/* File: dv/msido_bench.sv */
/*
  self-checking bench of the status input and discrete output block.
  assumes TICK_CYCLES of 10, so one millisecond is ten clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module msido_bench;
  localparam int TK = 10;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  localparam logic [31:0] ONE = 32'h0000_0001;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = ZERO;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        demand_restart;
  logic        irq;
  logic [31:0] dem [3] = '{default: ZERO};
  logic [1:0]  energy_pulse = 2'b00;
  logic [1:0]  contact;
  logic [1:0]  idle = 2'b11;
  logic [1:0]  exp_pin = 2'b11;
  wire  [1:0]  dout;
  logic [31:0] rd_data;
  logic        rd_err;
  logic [31:0] db;
  logic [31:0] np;
  int          mismatches = 0;
  int          n_compared = 0;
  int          restarts = 0;
  int          n;
  int          p0;

  msido_top #(.TICK_CYCLES(TK)) DUT (
    .clock(clock), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .status_input_one(contact[0]), .status_input_two(contact[1]),
    .demand_present(dem[0]), .demand_last(dem[1]), .demand_predict(dem[2]),
    .energy_pulse(energy_pulse), .demand_restart(demand_restart),
    .discrete_output_one(dout[0]), .discrete_output_two(dout[1]), .irq(irq));

  msido_field u_field (.clock(clock), .dout(dout), .idle(idle), .contact(contact));

  // ----------------------------------------------------------------------
  // clock, watchdog and helpers
  // ----------------------------------------------------------------------
  initial forever #25 clock = ~clock;

  always @(posedge clock) if (demand_restart === 1'b1) restarts++;

  initial begin
    repeat (100000) @(posedge clock);
    mismatches++;
    conclude();
  end

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // setup, access, then hold until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, ZERO);
    chk(nm, exp, rd_data);
  endtask

  task automatic await(input int ch, input logic v, input int lim, output int k);
    k = 0;
    while (dout[ch] !== v && k < lim) begin
      @(posedge clock);
      k++;
    end
  endtask

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(94610));
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    chk("idle pins", 32'(exp_pin), 32'(dout));
    rd("cfg one", msido_pkg::OFS_OUT_CFG0, 32'h0000_0010);
    rd("cfg two", msido_pkg::OFS_OUT_CFG1, 32'h0000_0010);
    apb(1'b0, 12'h040, ONE);
    chk("unmapped err", ONE, 32'(rd_err));
    chk("unmapped data", ZERO, rd_data);
    // channel, command and polarity in every combination, other pin untouched
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, k[0] ? msido_pkg::OFS_OUT_CFG1 : msido_pkg::OFS_OUT_CFG0, 32'({k[2], 1'b0, k[1], 2'b00}));
      exp_pin[k[0]] = k[1] ^ k[2];
      repeat (2) @(posedge clock);
      chk("switch", 32'(exp_pin), 32'(dout));
      apb(1'b0, msido_pkg::OFS_STATE, ZERO);
      chk("state", 32'(k[1]), 32'(rd_data[2 + k[0]]));
    end
    // bounced presses count, a short closure does not, input two resyncs
    db = 2 + $urandom % 4;
    np = 1 + $urandom % 4;
    apb(1'b1, msido_pkg::OFS_DEBOUNCE0, db);
    apb(1'b1, msido_pkg::OFS_DEBOUNCE1, db);
    apb(1'b1, msido_pkg::OFS_IN_MODE, 32'h0000_0002);
    for (int i = 0; i < np; i++) begin
      fork
        u_field.press(0, $urandom % 4, (db + 2) * TK, (db + 2) * TK);
        u_field.press(1, 1, (db + 2) * TK, (db + 2) * TK);
      join
    end
    u_field.press(0, 0, (db - 1) * TK - 5, (db + 2) * TK);
    rd("count one", msido_pkg::OFS_COUNT0, np);
    rd("count two", msido_pkg::OFS_COUNT1, ZERO);
    chk("restarts", np, 32'(restarts));
    // energy pulses ignore the on-time setting
    apb(1'b1, msido_pkg::OFS_ON_TIME0, ONE);
    apb(1'b1, msido_pkg::OFS_OUT_CFG0, 32'h0000_0012);
    apb(1'b1, msido_pkg::OFS_OUT_CFG1, 32'h0000_0012);
    for (int ch = 0; ch < 2; ch++) begin
      p0 = u_field.pulses[ch];
      energy_pulse[ch] <= 1'b1;
      @(posedge clock);
      energy_pulse <= 2'b00;
      await(ch, 1'b0, 50, n);
      await(ch, 1'b1, 1000, n);
      chk("energy width", 20 * TK, n);
      chk("received", p0 + 1, u_field.pulses[ch]);
    end
    // timed output: one second on the rising command
    apb(1'b1, msido_pkg::OFS_OUT_CFG0, 32'h0000_0008);
    apb(1'b1, msido_pkg::OFS_OUT_CFG0, 32'h0000_000C);
    await(0, 1'b1, 50, n);
    await(0, 1'b0, 20000, n);
    chk("timed width", 1000 * TK, n);
    // demand alarm for each source; input interrupts stay masked
    apb(1'b1, msido_pkg::OFS_OUT_CFG1, ONE);
    apb(1'b1, msido_pkg::OFS_DEM_LIMIT, 32'h0000_03E8);
    apb(1'b1, msido_pkg::OFS_DEM_DROP, 32'h0000_01F4);
    apb(1'b1, msido_pkg::OFS_IRQ_EN, 32'h0000_0004);
    repeat (2) @(posedge clock);
    chk("irq masked", ZERO, 32'(irq));
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, msido_pkg::OFS_DEM_SEL, s);
      for (int j = 0; j < 3; j++)
        dem[j] <= (j == s) ? ZERO : 32'h0000_0400 + $urandom % 1000;
      repeat (8) @(posedge clock);
      chk("unselected", ZERO, 32'(dout[1]));
      dem[s] <= 32'h0000_03E9 + $urandom % 1000;
      await(1, 1'b1, 20, n);
      repeat (3) @(posedge clock);
      chk("alarm on", ONE, 32'(dout[1]));
      chk("irq", ONE, 32'(irq));
      dem[s] <= 32'h0000_01F4 + $urandom % 500;
      repeat (8) @(posedge clock);
      chk("alarm hold", ONE, 32'(dout[1]));
      dem <= '{default: 32'h0000_01F3};
      await(1, 1'b0, 20, n);
      chk("alarm drop", ZERO, 32'(dout[1]));
      apb(1'b1, msido_pkg::OFS_IRQ_CLR, 32'h0000_0004);
      repeat (3) @(posedge clock);
      chk("irq clear", ZERO, 32'(irq));
    end
    rd("clear reads", msido_pkg::OFS_IRQ_CLR, ZERO);
    conclude();
  end
endmodule

`default_nettype wire
